// >>> logic/spp_params.svh
// Constants for the scanner pixel pipeline: offsets, encodings, layout.
// Assumes inclusion by its bare name from the package and the top module.
//
// What this block does
// - Take 16-bit converter samples arriving at up to 6 MHz.
// - Horizontal divider offers factors 1, 1.5, 2, 3, 4, 6, 8, 12.
// - Each reduced pixel is the average of its group of inputs; at 1.5, a 2:1 weighted average of two inputs.
// - Output count per line is integer part of inputs over factor.
// - Leftover inputs at line end are dropped, no partial pixel.
// - Order is offset, gain, gamma, packing, then line buffer.
// - Subtract a per-pixel 16-bit offset word read from DRAM.
// - Offset subtraction stops at zero instead of wrapping.
// - Multiply by per-pixel 16-bit gain word, divide by 16384.
// - Gain results above 65535 become 65535.
// - Gain word zero gives zero; 16384 is unity gain.
// - Three colour gamma tables indexed by top 12 bits, 8-bit result.
// - Tables take 12k DRAM words, 4K per colour, low byte used.
// - Host loads tables through the port; colour field picks the table.
// - At 8, 4, 2, 1 bit depth pack top bits into 16-bit words.
// - Earliest pixel lands at bit 15, each pixel MSB first.
// - Incomplete last packed word of a line is not stored.
// - Config register 9 bit 5 selects 16-bit mode, bypassing gamma, packing.
// - In 16-bit mode pixel bits keep their positions in the word.
// - Line buffer is a DRAM FIFO, filled per stored word, drained independently.
// - DRAM of 256k by 16 or 1M by 16 is supported.
// - 108k words hold coefficients and tables; the rest buffers lines, from 96k on in 16-bit mode.
`ifndef SPP_PARAMS_SVH
`define SPP_PARAMS_SVH
`define SPP_PIX_W 16
`define SPP_ADDR_W 20
`define SPP_IDX_CFG 8'h09
`define SPP_IDX_STAT 8'h10
`define SPP_IDX_DPA 8'h11
`define SPP_IDX_DPD 8'h12
`define SPP_CFG_RST 8'h00
`define SPP_STAT_OVF 20
`define SPP_STAT_LOST 21
`define SPP_DP_RD_BIT 15
`define SPP_OFS_BASE 20'h00000
`define SPP_GAIN_BASE 20'h0C000
`define SPP_GAM_BASE 20'h18000
`define SPP_BUF_BASE 20'h1B000
`define SPP_TOP_256K 20'h3FFFF
`define SPP_TOP_1M 20'hFFFFF
`define SPP_GAIN_SHIFT 14
`define SPP_UNITY 16'h4000
`define SPP_SAT 16'hFFFF
`define SPP_DIV_1 3'h0
`define SPP_DIV_1P5 3'h1
`define SPP_DIV_2 3'h2
`define SPP_DIV_3 3'h3
`define SPP_DIV_4 3'h4
`define SPP_DIV_6 3'h5
`define SPP_DIV_8 3'h6
`define SPP_DIV_12 3'h7
`define SPP_DEP_8 2'h0
`define SPP_DEP_4 2'h1
`define SPP_DEP_2 2'h2
`define SPP_DEP_1 2'h3
`endif

// >>> logic/spp_pixel_pipeline.sv
// Pixel pipeline: averaging, offset, gain, gamma, packing, DRAM line FIFO.
// Assumes an AHB-Lite master on CLK, a sample source on CLK and a DRAM port
// that returns read data in the cycle after the read strobe.
//
// Local design decisions: the AHB-Lite register port and the placing of the registers.
`include "spp_params.svh"
module spp_pixel_pipeline import spp_pkg::*; (
  input logic CLK,
  input logic RST,
  input logic HSEL,
  input logic [31:0] HADDR,
  input logic [1:0] HTRANS,
  input logic HWRITE,
  input logic [2:0] HSIZE,
  input logic [31:0] HWDATA,
  input logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input logic [15:0] PIX_IN,
  input logic PIX_VALID,
  input logic [1:0] PIX_COLOR,
  input logic LINE_START,
  output logic [19:0] MEM_ADDR,
  output logic MEM_RE,
  output logic MEM_WE,
  output logic [15:0] MEM_WDATA,
  input logic [15:0] MEM_RDATA,
  input logic DRAIN_REQ,
  output logic [15:0] DRAIN_DATA,
  output logic DRAIN_VALID
);

  // Last count index of an averaging group
  function automatic logic [3:0] grp_last(input logic [2:0] d);
    case (d)
      `SPP_DIV_1: grp_last = 4'h0;
      `SPP_DIV_2: grp_last = 4'h1;
      `SPP_DIV_3: grp_last = 4'h2;
      `SPP_DIV_4: grp_last = 4'h3;
      `SPP_DIV_6: grp_last = 4'h5;
      `SPP_DIV_8: grp_last = 4'h7;
      `SPP_DIV_12: grp_last = 4'hB;
      default: grp_last = 4'h2;
    endcase
  endfunction

  // Truncating average of a group sum
  function automatic logic [15:0] avg_div(input logic [19:0] s, input logic [2:0] d);
    logic [19:0] q;
    case (d)
      `SPP_DIV_1: q = s;
      `SPP_DIV_2: q = s >> 1;
      `SPP_DIV_4: q = s >> 2;
      `SPP_DIV_6: q = s / 20'h00006;
      `SPP_DIV_8: q = s >> 3;
      `SPP_DIV_12: q = s / 20'h0000C;
      default: q = s / 20'h00003;
    endcase
    avg_div = q[15:0];
  endfunction

  // Pixels per packed word, minus one
  function automatic logic [4:0] pk_last(input logic [1:0] dp);
    case (dp)
      `SPP_DEP_8: pk_last = 5'h01;
      `SPP_DEP_4: pk_last = 5'h03;
      `SPP_DEP_2: pk_last = 5'h07;
      default: pk_last = 5'h0F;
    endcase
  endfunction

  spp_cfg_t cfg_ff, nxt_cfg;
  logic bus_wr_ff, nxt_bus_wr;
  logic [7:0] bus_idx_ff, nxt_bus_idx;
  logic [31:0] hrdata_ff, nxt_hrdata;
  logic [19:0] acc_ff, nxt_acc;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [15:0] prev_ff, nxt_prev;
  logic pend_ff, nxt_pend;
  logic [15:0] pend_pix_ff, nxt_pend_pix;
  logic [1:0] pend_col_ff, nxt_pend_col;
  logic [13:0] pend_idx_ff, nxt_pend_idx;
  logic [13:0] oidx_ff, nxt_oidx;
  logic lost_ff, nxt_lost;
  spp_state_t st_ff, nxt_st;
  spp_mem_t mem_ff, nxt_mem;
  logic [15:0] wk_ff, nxt_wk;
  logic [1:0] col_ff, nxt_col;
  logic [13:0] idx_ff, nxt_idx;
  logic [15:0] pk_ff, nxt_pk;
  logic [4:0] pkn_ff, nxt_pkn;
  logic [19:0] wp_ff, nxt_wp;
  logic [19:0] rp_ff, nxt_rp;
  logic [19:0] fill_ff, nxt_fill;
  logic ovf_ff, nxt_ovf;
  logic [13:0] dp_addr_ff, nxt_dp_addr;
  logic dp_pend_ff, nxt_dp_pend;
  logic dp_rd_ff, nxt_dp_rd;
  logic [15:0] dp_wdata_ff, nxt_dp_wdata;
  logic [15:0] dp_rdata_ff, nxt_dp_rdata;
  logic [15:0] drn_data_ff, nxt_drn_data;
  logic drn_vld_ff, nxt_drn_vld;

  logic bus_go, wr_cfg, wr_stat, wr_dpa, wr_dpd, pend_take;
  logic [19:0] buf_base, buf_top, buf_cap;
  logic full, empty;

  // Data-phase write strobes
  assign wr_cfg = bus_wr_ff && bus_idx_ff == `SPP_IDX_CFG;
  assign wr_stat = bus_wr_ff && bus_idx_ff == `SPP_IDX_STAT;
  assign wr_dpa = bus_wr_ff && bus_idx_ff == `SPP_IDX_DPA;
  assign wr_dpd = bus_wr_ff && bus_idx_ff == `SPP_IDX_DPD;
  assign bus_go = HSEL && HTRANS[1] && HREADY;
  assign pend_take = st_ff == S_IDLE && pend_ff;

  // Buffer window; 16-bit mode reuses gamma area
  assign buf_base = cfg_ff.mode16 ? `SPP_GAM_BASE : `SPP_BUF_BASE;
  assign buf_top = cfg_ff.dram_1m ? `SPP_TOP_1M : `SPP_TOP_256K;
  assign buf_cap = buf_top - buf_base + 20'h00001;
  assign full = fill_ff == buf_cap;
  assign empty = fill_ff == 20'h00000;

  // Circular pointer step
  function automatic logic [19:0] ptr_step(input logic [19:0] p, input logic [19:0] b,
                                           input logic [19:0] t);
    ptr_step = (p == t) ? b : p + 20'h00001;
  endfunction

  // Bus slave: zero wait, read data at address phase
  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_bus_wr = bus_go && HWRITE;
    nxt_bus_idx = bus_go ? HADDR[9:2] : bus_idx_ff;
    nxt_hrdata = hrdata_ff;
    if (wr_cfg) begin
      nxt_cfg = spp_cfg_t'(HWDATA[7:0]);
    end
    if (bus_go && !HWRITE) begin
      case (HADDR[9:2])
        `SPP_IDX_CFG: nxt_hrdata = {24'h000000, cfg_ff};
        `SPP_IDX_STAT: nxt_hrdata = {8'h00, dp_pend_ff, empty, lost_ff, ovf_ff, fill_ff};
        `SPP_IDX_DPA: nxt_hrdata = {16'h0000, dp_rd_ff, 1'b0, dp_addr_ff};
        `SPP_IDX_DPD: nxt_hrdata = {16'h0000, dp_rdata_ff};
        default: nxt_hrdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      cfg_ff <= spp_cfg_t'(`SPP_CFG_RST);
      bus_wr_ff <= 1'b0;
      bus_idx_ff <= 8'h00;
      hrdata_ff <= 32'h00000000;
    end else begin
      cfg_ff <= nxt_cfg;
      bus_wr_ff <= nxt_bus_wr;
      bus_idx_ff <= nxt_bus_idx;
      hrdata_ff <= nxt_hrdata;
    end
  end

  // Horizontal averaging into a one-pixel hold slot
  always_comb begin
    logic [19:0] a0, sum, s15;
    logic [3:0] c0;
    logic [13:0] o0;
    logic emit;
    logic [15:0] epix;
    a0 = LINE_START ? 20'h00000 : acc_ff;
    c0 = LINE_START ? 4'h0 : cnt_ff;
    o0 = LINE_START ? 14'h0000 : oidx_ff;
    sum = a0 + {4'h0, PIX_IN};
    s15 = 20'h00000;
    emit = 1'b0;
    epix = 16'h0000;
    nxt_acc = a0;
    nxt_cnt = c0;
    nxt_oidx = o0;
    nxt_prev = prev_ff;
    nxt_pend = pend_take ? 1'b0 : pend_ff;
    nxt_pend_pix = pend_pix_ff;
    nxt_pend_col = pend_col_ff;
    nxt_pend_idx = pend_idx_ff;
    nxt_lost = (wr_stat && HWDATA[`SPP_STAT_LOST]) ? 1'b0 : lost_ff;
    if (PIX_VALID && cfg_ff.enable) begin
      if (cfg_ff.div == `SPP_DIV_1P5) begin
        nxt_prev = PIX_IN;
        case (c0)
          4'h0: begin
            nxt_cnt = 4'h1;
          end
          4'h1: begin
            s15 = {3'h0, prev_ff, 1'b0} + {4'h0, PIX_IN};
            emit = 1'b1;
            nxt_cnt = 4'h2;
          end
          default: begin
            s15 = {4'h0, prev_ff} + {3'h0, PIX_IN, 1'b0};
            emit = 1'b1;
            nxt_cnt = 4'h0;
          end
        endcase
        epix = avg_div(s15, `SPP_DIV_1P5);
      end else if (c0 == grp_last(cfg_ff.div)) begin
        emit = 1'b1;
        epix = avg_div(sum, cfg_ff.div);
        nxt_acc = 20'h00000;
        nxt_cnt = 4'h0;
      end else begin
        nxt_acc = sum;
        nxt_cnt = c0 + 4'h1;
      end
    end
    if (emit) begin
      if (pend_ff && !pend_take) begin
        nxt_lost = 1'b1;
      end
      nxt_pend = 1'b1;
      nxt_pend_pix = epix;
      nxt_pend_col = PIX_COLOR;
      nxt_pend_idx = o0;
      nxt_oidx = o0 + 14'h0001;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      acc_ff <= 20'h00000;
      cnt_ff <= 4'h0;
      prev_ff <= 16'h0000;
      pend_ff <= 1'b0;
      pend_pix_ff <= 16'h0000;
      pend_col_ff <= 2'h0;
      pend_idx_ff <= 14'h0000;
      oidx_ff <= 14'h0000;
      lost_ff <= 1'b0;
    end else begin
      acc_ff <= nxt_acc;
      cnt_ff <= nxt_cnt;
      prev_ff <= nxt_prev;
      pend_ff <= nxt_pend;
      pend_pix_ff <= nxt_pend_pix;
      pend_col_ff <= nxt_pend_col;
      pend_idx_ff <= nxt_pend_idx;
      oidx_ff <= nxt_oidx;
      lost_ff <= nxt_lost;
    end
  end

  // Correction sequencer and DRAM port owner
  always_comb begin
    logic [31:0] prod;
    logic [15:0] g16;
    logic [15:0] bw;
    logic do_bw;
    logic [15:0] pkv;
    spp_cfg_t wcfg;
    prod = 32'h00000000;
    g16 = 16'h0000;
    bw = 16'h0000;
    do_bw = 1'b0;
    pkv = pk_ff;
    wcfg = spp_cfg_t'(HWDATA[7:0]);
    nxt_st = st_ff;
    nxt_mem = '0;
    nxt_wk = wk_ff;
    nxt_col = col_ff;
    nxt_idx = idx_ff;
    nxt_pk = pk_ff;
    nxt_pkn = pkn_ff;
    nxt_wp = wp_ff;
    nxt_rp = rp_ff;
    nxt_fill = fill_ff;
    nxt_ovf = (wr_stat && HWDATA[`SPP_STAT_OVF]) ? 1'b0 : ovf_ff;
    nxt_dp_addr = dp_addr_ff;
    nxt_dp_pend = dp_pend_ff;
    nxt_dp_rd = dp_rd_ff;
    nxt_dp_wdata = dp_wdata_ff;
    nxt_dp_rdata = dp_rdata_ff;
    nxt_drn_data = drn_data_ff;
    nxt_drn_vld = 1'b0;
    case (st_ff)
      S_IDLE: begin
        if (pend_ff) begin
          nxt_wk = pend_pix_ff;
          nxt_col = pend_col_ff;
          nxt_idx = pend_idx_ff;
          nxt_mem.re = 1'b1;
          nxt_mem.addr = `SPP_OFS_BASE + {4'h0, pend_col_ff, pend_idx_ff};
          nxt_st = S_OFS_RQ;
        end else if (dp_pend_ff) begin
          nxt_mem.addr = `SPP_GAM_BASE + {6'h00, dp_addr_ff};
          if (dp_rd_ff) begin
            nxt_mem.re = 1'b1;
            nxt_st = S_DP_RQ;
          end else begin
            nxt_mem.we = 1'b1;
            nxt_mem.wdata = dp_wdata_ff;
            nxt_dp_pend = 1'b0;
            nxt_dp_addr = {dp_addr_ff[13:12], dp_addr_ff[11:0] + 12'h001};
          end
        end else if (DRAIN_REQ && !empty && !drn_vld_ff) begin
          nxt_mem.re = 1'b1;
          nxt_mem.addr = rp_ff;
          nxt_st = S_DRN_RQ;
        end
      end
      S_OFS_RQ: nxt_st = S_OFS_DT;
      S_OFS_DT: begin
        nxt_wk = (MEM_RDATA > wk_ff) ? 16'h0000 : wk_ff - MEM_RDATA;
        nxt_mem.re = 1'b1;
        nxt_mem.addr = `SPP_GAIN_BASE + {4'h0, col_ff, idx_ff};
        nxt_st = S_GAIN_RQ;
      end
      S_GAIN_RQ: nxt_st = S_GAIN_DT;
      S_GAIN_DT: begin
        prod = {16'h0000, wk_ff} * {16'h0000, MEM_RDATA};
        // Saturate when any bit lands above the 16-bit result window
        g16 = (|(prod >> (`SPP_GAIN_SHIFT + 16))) ? `SPP_SAT : 16'(prod >> `SPP_GAIN_SHIFT);
        nxt_wk = g16;
        if (cfg_ff.mode16) begin
          do_bw = 1'b1;
          bw = g16;
          nxt_st = S_IDLE;
        end else begin
          nxt_mem.re = 1'b1;
          nxt_mem.addr = `SPP_GAM_BASE + {6'h00, col_ff, g16[15:4]};
          nxt_st = S_GAM_RQ;
        end
      end
      S_GAM_RQ: nxt_st = S_GAM_DT;
      S_GAM_DT: begin
        case (cfg_ff.depth)
          `SPP_DEP_8: pkv = {pk_ff[7:0], MEM_RDATA[7:0]};
          `SPP_DEP_4: pkv = {pk_ff[11:0], MEM_RDATA[7:4]};
          `SPP_DEP_2: pkv = {pk_ff[13:0], MEM_RDATA[7:6]};
          default: pkv = {pk_ff[14:0], MEM_RDATA[7]};
        endcase
        nxt_pk = pkv;
        nxt_pkn = pkn_ff + 5'h01;
        if (pkn_ff == pk_last(cfg_ff.depth)) begin
          do_bw = 1'b1;
          bw = pkv;
          nxt_pkn = 5'h00;
        end
        nxt_st = S_IDLE;
      end
      S_DP_RQ: nxt_st = S_DP_DT;
      S_DP_DT: begin
        nxt_dp_rdata = MEM_RDATA;
        nxt_dp_pend = 1'b0;
        nxt_dp_rd = 1'b0;
        nxt_st = S_IDLE;
      end
      S_DRN_RQ: nxt_st = S_DRN_DT;
      S_DRN_DT: begin
        nxt_drn_data = MEM_RDATA;
        nxt_drn_vld = 1'b1;
        nxt_rp = ptr_step(rp_ff, buf_base, buf_top);
        nxt_fill = fill_ff - 20'h00001;
        nxt_st = S_IDLE;
      end
      default: nxt_st = S_IDLE;
    endcase
    // Store one word into the FIFO, or flag overflow
    if (do_bw) begin
      if (full) begin
        nxt_ovf = 1'b1;
      end else begin
        nxt_mem.we = 1'b1;
        nxt_mem.addr = wp_ff;
        nxt_mem.wdata = bw;
        nxt_wp = ptr_step(wp_ff, buf_base, buf_top);
        nxt_fill = fill_ff + 20'h00001;
      end
    end
    if (LINE_START) begin
      nxt_pk = 16'h0000;
      nxt_pkn = 5'h00;
    end
    // Data port commands from the bus
    if (wr_dpa) begin
      nxt_dp_addr = HWDATA[13:0];
      nxt_dp_rd = HWDATA[`SPP_DP_RD_BIT];
      nxt_dp_pend = HWDATA[`SPP_DP_RD_BIT] | dp_pend_ff;
    end else if (wr_dpd) begin
      nxt_dp_wdata = HWDATA[15:0];
      nxt_dp_rd = 1'b0;
      nxt_dp_pend = 1'b1;
    end
    if (wr_cfg) begin
      nxt_wp = wcfg.mode16 ? `SPP_GAM_BASE : `SPP_BUF_BASE;
      nxt_rp = nxt_wp;
      nxt_fill = 20'h00000;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      st_ff <= S_IDLE;
      mem_ff <= '0;
      wk_ff <= 16'h0000;
      col_ff <= 2'h0;
      idx_ff <= 14'h0000;
      pk_ff <= 16'h0000;
      pkn_ff <= 5'h00;
      wp_ff <= `SPP_BUF_BASE;
      rp_ff <= `SPP_BUF_BASE;
      fill_ff <= 20'h00000;
      ovf_ff <= 1'b0;
      dp_addr_ff <= 14'h0000;
      dp_pend_ff <= 1'b0;
      dp_rd_ff <= 1'b0;
      dp_wdata_ff <= 16'h0000;
      dp_rdata_ff <= 16'h0000;
      drn_data_ff <= 16'h0000;
      drn_vld_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      mem_ff <= nxt_mem;
      wk_ff <= nxt_wk;
      col_ff <= nxt_col;
      idx_ff <= nxt_idx;
      pk_ff <= nxt_pk;
      pkn_ff <= nxt_pkn;
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
      fill_ff <= nxt_fill;
      ovf_ff <= nxt_ovf;
      dp_addr_ff <= nxt_dp_addr;
      dp_pend_ff <= nxt_dp_pend;
      dp_rd_ff <= nxt_dp_rd;
      dp_wdata_ff <= nxt_dp_wdata;
      dp_rdata_ff <= nxt_dp_rdata;
      drn_data_ff <= nxt_drn_data;
      drn_vld_ff <= nxt_drn_vld;
    end
  end

  // Output drive, from flops except the constant HREADYOUT and HRESP
  assign HRDATA = hrdata_ff;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign MEM_ADDR = mem_ff.addr;
  assign MEM_RE = mem_ff.re;
  assign MEM_WE = mem_ff.we;
  assign MEM_WDATA = mem_ff.wdata;
  assign DRAIN_DATA = drn_data_ff;
  assign DRAIN_VALID = drn_vld_ff;

  // Correction chain steps
  sequence s_ofs_chain;
    st_ff == S_OFS_RQ ##1 st_ff == S_OFS_DT ##1 st_ff == S_GAIN_RQ;
  endsequence
  property p_order;
    @(posedge CLK) disable iff (RST) st_ff == S_OFS_RQ |-> s_ofs_chain ##1 st_ff == S_GAIN_DT;
  endproperty
  a_order: assert property (p_order) else $error("correction order broken");
  property p_ofs_rd;
    @(posedge CLK) disable iff (RST) st_ff == S_OFS_RQ |-> MEM_RE && MEM_ADDR < `SPP_GAIN_BASE;
  endproperty
  a_ofs_rd: assert property (p_ofs_rd) else $error("offset fetch missing");
  property p_clamp0;
    @(posedge CLK) disable iff (RST)
      st_ff == S_OFS_DT && MEM_RDATA > wk_ff |=> wk_ff == 16'h0000;
  endproperty
  a_clamp0: assert property (p_clamp0) else $error("offset wrapped");
  property p_unity;
    @(posedge CLK) disable iff (RST)
      st_ff == S_GAIN_DT && MEM_RDATA == `SPP_UNITY |=> wk_ff == $past(wk_ff);
  endproperty
  a_unity: assert property (p_unity) else $error("unity gain altered pixel");
  property p_zero_gain;
    @(posedge CLK) disable iff (RST)
      st_ff == S_GAIN_DT && MEM_RDATA == 16'h0000 |=> wk_ff == 16'h0000;
  endproperty
  a_zero_gain: assert property (p_zero_gain) else $error("zero gain not zero");
  property p_mode16;
    @(posedge CLK) disable iff (RST)
      st_ff == S_GAIN_DT && cfg_ff.mode16 && !full |=> MEM_WE && MEM_WDATA == wk_ff;
  endproperty
  a_mode16: assert property (p_mode16) else $error("16-bit store wrong");
  property p_line_clear;
    @(posedge CLK) disable iff (RST)
      LINE_START && !PIX_VALID |=> cnt_ff == 4'h0 && acc_ff == 20'h00000 && pkn_ff == 5'h00;
  endproperty
  a_line_clear: assert property (p_line_clear) else $error("line residue kept");
  property p_avg2;
    @(posedge CLK) disable iff (RST)
      PIX_VALID && cfg_ff.enable && !LINE_START && cfg_ff.div == `SPP_DIV_2 && cnt_ff == 4'h1
      |=> pend_ff && pend_pix_ff == 16'(($past(acc_ff) + {4'h0, $past(PIX_IN)}) >> 1);
  endproperty
  a_avg2: assert property (p_avg2) else $error("pair average wrong");
endmodule

// >>> logic/spp_pkg.sv
// Types for the scanner pixel pipeline.
// Assumes the constants header is on the include path.
`include "spp_params.svh"
package spp_pkg;
  // Configuration word, register 9
  typedef struct packed {
    logic enable;
    logic dram_1m;
    logic mode16;
    logic [1:0] depth;
    logic [2:0] div;
  } spp_cfg_t;

  // One DRAM command
  typedef struct packed {
    logic re;
    logic we;
    logic [`SPP_ADDR_W-1:0] addr;
    logic [`SPP_PIX_W-1:0] wdata;
  } spp_mem_t;

  typedef enum logic [3:0] {
    S_IDLE, S_OFS_RQ, S_OFS_DT, S_GAIN_RQ, S_GAIN_DT, S_GAM_RQ, S_GAM_DT,
    S_DP_RQ, S_DP_DT, S_DRN_RQ, S_DRN_DT
  } spp_state_t;
endpackage

// >>> verification/spp_dram_model.sv
// DRAM partner model: 1M x 16 store for coefficients, gamma tables and line buffer.
// Assumes strobes are sampled on the rising edge; read data stands for one cycle.
module spp_dram_model (
  input wire logic clk,
  input wire logic [19:0] addr,
  input wire logic re,
  input wire logic we,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:20'hFFFFF];
  initial rdata = 16'h0000;
  // Store writes; answer a read next cycle, then the bus toggles
  always @(posedge clk) begin
    if (we) mem[addr] <= wdata;
    rdata <= re ? mem[addr] : ~rdata;
  end
endmodule

// >>> verification/spp_pixel_pipeline_tb.sv
// Testbench: corrections, averaging, gamma packing and drain of the pixel pipeline.
// Assumes the DRAM model answers reads one cycle after the strobe.
`include "spp_params.svh"
module spp_pixel_pipeline_tb import spp_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, hsel = 0, hwrite = 0, pix_valid = 0, line_start = 0, drain_req = 0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata;
  logic [1:0] htrans = '0, pix_color = '0;
  logic [2:0] hsize = 3'h2;
  logic [15:0] pix_in = '0, mem_rdata, mem_wdata, drain_data;
  logic [19:0] mem_addr;
  logic hreadyout, hresp, mem_re, mem_we, drain_valid;
  int n_mismatch = 0, comparisons = 0;
  logic [15:0] wq[$];
  logic [19:0] aq[$];
  localparam int NDIV [8] = '{1, 1, 2, 3, 4, 6, 8, 12};
  localparam logic [15:0] CP [6] = '{16'h03E8, 16'h0064, 16'hEA60, 16'h1388, 16'h2328, 16'hA5C3};
  localparam logic [15:0] CO [6] = '{16'h00C8, 16'h012C, 16'h0000, 16'h03E8, 16'h03E8, 16'h0000};
  localparam logic [15:0] CG [6] = '{16'h4000, 16'h4000, 16'h8000, 16'h0000, 16'h2000, 16'h4000};
  localparam logic [15:0] CE [6] = '{16'h0320, 16'h0000, 16'hFFFF, 16'h0000, 16'h0FA0, 16'hA5C3};
  always #4 clk = ~clk;
  spp_pixel_pipeline dut (.CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .PIX_IN(pix_in), .PIX_VALID(pix_valid),
    .PIX_COLOR(pix_color), .LINE_START(line_start), .MEM_ADDR(mem_addr), .MEM_RE(mem_re),
    .MEM_WE(mem_we), .MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata), .DRAIN_REQ(drain_req),
    .DRAIN_DATA(drain_data), .DRAIN_VALID(drain_valid));
  spp_dram_model dram (.clk(clk), .addr(mem_addr), .re(mem_re), .we(mem_we),
    .wdata(mem_wdata), .rdata(mem_rdata));
  // Record every DRAM store with its address
  always @(posedge clk) begin
    if (mem_we) begin
      wq.push_back(mem_wdata);
      aq.push_back(mem_addr);
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask
  task automatic pulse_line();
    line_start <= 1'b1;
    @(posedge clk);
    line_start <= 1'b0;
  endtask
  task automatic new_line(input spp_cfg_t c);
    wr(`SPP_IDX_CFG, {24'h0, c});
    wq.delete();
    aq.delete();
    pulse_line();
  endtask
  // One sample every 21 clocks, just under 6 MHz
  task automatic pix(input logic [15:0] v);
    pix_in <= v;
    pix_valid <= 1'b1;
    @(posedge clk);
    pix_valid <= 1'b0;
    repeat (20) @(posedge clk);
  endtask
  task automatic coef(input int k, input logic [15:0] o, input logic [15:0] g);
    dram.mem[`SPP_OFS_BASE + 20'(k)] = o;
    dram.mem[`SPP_GAIN_BASE + 20'(k)] = g;
  endtask
  function automatic int px(input int i);
    return 4096 + 309 * i;
  endfunction
  // Expected average for a divide setting and output index
  function automatic logic [15:0] avg(input int d, input int k);
    int s = 0;
    int g = 3 * (k / 2);
    if (d == 1) return 16'((k % 2) ? (px(g + 1) + 2 * px(g + 2)) / 3 : (2 * px(g) + px(g + 1)) / 3);
    for (int i = 0; i < NDIV[d]; i++) s += px(k * NDIV[d] + i);
    return 16'(s / NDIV[d]);
  endfunction
  function automatic logic [7:0] gam(input int e);
    return 8'(e * 17);
  endfunction
  function automatic logic [15:0] packed_word(input int bits);
    logic [15:0] w = '0;
    for (int i = 0; i < 16 / bits; i++) w = (w << bits) | 16'(gam(i) >> (8 - bits));
    return w;
  endfunction
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    complete_run();
  end
  // Main sequence
  initial begin
    logic [31:0] r;
    int t;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, `SPP_IDX_CFG, 32'h0, r);
    check("config reset", r, 32'h0);
    wr(8'h01, 32'hFFFFFFFF);
    bus(1'b0, 8'h01, 32'h0, r);
    check("unmapped read", r, 32'h0);
    // Offset, gain and clamps in 16-bit mode
    for (int k = 0; k < 6; k++) coef(k, CO[k], CG[k]);
    new_line('{1'b1, 1'b0, 1'b1, 2'h0, `SPP_DIV_1});
    for (int k = 0; k < 6; k++) pix(CP[k]);
    pulse_line();
    check("store count", wq.size(), 6);
    check("16-bit buffer start", aq[0], `SPP_GAM_BASE);
    foreach (CE[k]) check("corrected", wq[k], CE[k]);
    drain_req <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      t = 0;
      do begin
        @(posedge clk);
        t++;
      end while (drain_valid !== 1'b1 && t < 50);
      check("drain valid", drain_valid, 1'b1);
      check("drained", drain_data, CE[i]);
    end
    drain_req <= 1'b0;
    repeat (4) @(posedge clk);
    bus(1'b0, `SPP_IDX_STAT, 32'h0, r);
    check("status empty", r & 32'h00FFFFFF, 32'h00400000);
    // Every divide setting over a 13-pixel line
    for (int k = 0; k < 17; k++) coef(k, 16'h0000, `SPP_UNITY);
    for (int d = 0; d < 8; d++) begin
      new_line('{1'b1, 1'b0, 1'b1, 2'h0, 3'(d)});
      for (int i = 0; i < 13; i++) pix(16'(px(i)));
      pulse_line();
      check("output count", wq.size(), d == 1 ? 8 : 13 / NDIV[d]);
      foreach (wq[k]) check("average", wq[k], avg(d, k));
    end
    // Reload the red table after 16-bit mode, then one blue write
    wr(`SPP_IDX_CFG, 32'h0);
    wq.delete();
    aq.delete();
    wr(`SPP_IDX_DPA, 32'h0000);
    for (int e = 0; e < 16; e++) wr(`SPP_IDX_DPD, {16'h0, 8'hA5, gam(e)});
    wr(`SPP_IDX_DPA, 32'h2000);
    wr(`SPP_IDX_DPD, 32'h0000);
    repeat (5) @(posedge clk);
    check("table store count", aq.size(), 17);
    check("red entry 15", aq[15], `SPP_GAM_BASE + 20'h0000F);
    check("blue entry 0", aq[16], `SPP_GAM_BASE + 20'h02000);
    // Read red entry 15 back through the data port
    wr(`SPP_IDX_DPA, 32'h800F);
    repeat (5) @(posedge clk);
    bus(1'b0, `SPP_IDX_DPD, 32'h0, r);
    check("table read", r, {16'h0000, 8'hA5, gam(15)});
    // Packing at each depth, one extra pixel left over
    for (int d = 0; d < 4; d++) begin
      new_line('{1'b1, 1'b0, 1'b0, 2'(d), `SPP_DIV_1});
      for (int i = 0; i <= 16 / (8 >> d); i++) pix(16'(i << 4));
      pulse_line();
      repeat (10) @(posedge clk);
      check("packed count", wq.size(), 1);
      check("packed word", wq[0], packed_word(8 >> d));
      check("buffer start", aq[0], `SPP_BUF_BASE);
    end
    complete_run();
  end
endmodule
